// ==== src/iacq_top.sv ====
// Image acquisition sequencer with register port and output line routing
// Functional notes
// - Four output lines, each carrying one selectable internal status signal.
// - A line at one means its output transistor conducts; zero means it does not.
// - After reset, line 1 shows exposure in progress, high through each exposure.
// - After reset, line 2 shows when a new exposure may start at the earliest.
// - Software may reassign which status signal drives each line.
// - With acquisition trigger off, acquisition runs from registers and commands only.
// - Single frame mode takes one image, transmits it, then stops.
// - Start command begins acquisition; exposure lasts the programmed exposure time.
// - Continuous mode acquires and transmits repeatedly after start, untriggered.
// - Continuous mode starts every following frame by itself.
// - Stop command ends acquisition and transmission at once.
// - Enabled pace limit slower than maximum gives exactly the programmed frame period.
// - Disabled or too fast pace limit gives the maximum frame rate.
`timescale 1ns/10ps
module iacq_top
	import iacq_pkg::*;
#(
	parameter int unsigned CNT_W = 24
) (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Register port
	input  wire logic [IACQ_AW-1:0]    addr_i,
	input  wire logic [IACQ_DW-1:0]    wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [IACQ_DW-1:0]    rdata_o,
	// Interrupt and transmission
	output logic                       irq_o,
	output logic                       frame_tx_o,
	// Output lines
	output logic      [IACQ_LINES-1:0] line_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		iacq_state_t           state;
		logic                  trig_sel;
		logic                  acq_trig_on;
		logic                  frm_trig_on;
		logic                  cont;
		logic                  limit_on;
		logic [CNT_W-1:0]      exposure;
		logic [CNT_W-1:0]      readout;
		logic [31:0]           pace;
		logic [7:0]            line_sel;
		logic [IACQ_IRQ_W-1:0] irq_stat;
		logic [IACQ_IRQ_W-1:0] irq_mask;
		logic [31:0]           period_cnt;
		logic [31:0]           frame_cnt;
		logic [IACQ_DW-1:0]    rdata;
		logic                  irq;
		logic                  tx;
	} iacq_top_t;

	localparam iacq_top_t RST_Q = '{
		state:    IACQ_IDLE,
		exposure: IACQ_EXPOSE_RST[CNT_W-1:0],
		readout:  IACQ_READ_RST[CNT_W-1:0],
		line_sel: IACQ_LINES_RST,
		default:  '0
	};

	iacq_top_t             q;
	iacq_top_t             d;
	logic                  tmr_load;
	logic [CNT_W-1:0]      tmr_count;
	logic                  tmr_abort;
	logic                  tmr_busy;
	logic                  tmr_done;
	logic                  start_cmd;
	logic                  stop_cmd;
	logic [31:0]           min_per;
	logic [31:0]           eff_per;
	logic                  exp_lvl;
	logic                  arm_lvl;
	logic [IACQ_IRQ_W-1:0] ev_set;
	logic [IACQ_IRQ_W-1:0] ev_clr;

	function automatic logic hit(input logic [IACQ_AW-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	iacq_stat_if stat ();

	iacq_phase_timer #(
		.W       (CNT_W)
	) u_timer (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.load_i  (tmr_load),
		.count_i (tmr_count),
		.abort_i (tmr_abort),
		.busy_o  (tmr_busy),
		.done_o  (tmr_done)
	);

	iacq_line_mux u_lines (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.stat    (stat),
		.line_o  (line_o)
	);

	assign exp_lvl           = (q.state == IACQ_EXPOSE) && tmr_busy;
	assign arm_lvl           = !q.acq_trig_on && ((q.state == IACQ_IDLE) ||
		((q.state == IACQ_PACE) && (q.period_cnt >= eff_per)));
	assign stat.exposing     = exp_lvl;
	assign stat.armable      = arm_lvl;
	assign stat.transmitting = q.tx;
	assign stat.line_sel     = q.line_sel;

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		start_cmd = wr_i && hit(addr_i, IACQ_OFS_CMD) && wdata_i[IACQ_CMD_START];
		stop_cmd  = wr_i && hit(addr_i, IACQ_OFS_CMD) && wdata_i[IACQ_CMD_STOP];
		// Shortest frame period: both phases plus sequencing overhead
		min_per   = 32'(q.exposure) + 32'(q.readout) + IACQ_OVERHEAD;
		eff_per   = (q.limit_on && (q.pace > min_per)) ? q.pace : min_per;
		tmr_load  = 1'b0;
		tmr_count = q.exposure;
		tmr_abort = 1'b0;
		ev_set    = '0;
		ev_clr    = '0;
		if (q.period_cnt != 32'hFFFFFFFF) begin
			d.period_cnt = q.period_cnt + 32'h1;
		end
		case (q.state)
			IACQ_IDLE: begin
				if (start_cmd && !stop_cmd) begin
					if (q.acq_trig_on) begin
						// Triggered start is not handled here
						ev_set[IACQ_IRQ_IGN] = 1'b1;
					end else begin
						tmr_load     = 1'b1;
						d.state      = IACQ_EXPOSE;
						d.period_cnt = 32'h1;
					end
				end
			end
			IACQ_EXPOSE: begin
				if (tmr_done) begin
					tmr_load  = 1'b1;
					tmr_count = q.readout;
					d.state   = IACQ_TRANSMIT;
				end
			end
			IACQ_TRANSMIT: begin
				if (tmr_done) begin
					ev_set[IACQ_IRQ_DONE] = 1'b1;
					d.frame_cnt = q.frame_cnt + 32'h1;
					d.state     = q.cont ? IACQ_PACE : IACQ_IDLE;
				end
			end
			IACQ_PACE: begin
				if (q.period_cnt >= eff_per) begin
					tmr_load     = 1'b1;
					d.state      = IACQ_EXPOSE;
					d.period_cnt = 32'h1;
				end
			end
			default: begin
				d.state = IACQ_IDLE;
			end
		endcase
		// A start while a frame is under way is dropped and flagged
		if (start_cmd && (q.state != IACQ_IDLE)) begin
			ev_set[IACQ_IRQ_IGN] = 1'b1;
		end
		if (stop_cmd) begin
			tmr_abort = 1'b1;
			d.state   = IACQ_IDLE;
			if (q.state != IACQ_IDLE) begin
				ev_set[IACQ_IRQ_STOP] = 1'b1;
			end
		end
		d.tx = (d.state == IACQ_TRANSMIT);

		// Register writes
		if (wr_i) begin
			case (addr_i)
				IACQ_OFS_CTRL: begin
					d.trig_sel = wdata_i[IACQ_CTRL_SEL];
					// Mode lands in the trigger that the selector names
					if (wdata_i[IACQ_CTRL_SEL] == IACQ_TSEL_ACQ) begin
						d.acq_trig_on = wdata_i[IACQ_CTRL_MODE];
					end else begin
						d.frm_trig_on = wdata_i[IACQ_CTRL_MODE];
					end
					d.cont     = wdata_i[IACQ_CTRL_CONT];
					d.limit_on = wdata_i[IACQ_CTRL_LIMIT];
				end
				IACQ_OFS_EXPOSE: d.exposure = wdata_i[CNT_W-1:0];
				IACQ_OFS_READ:   d.readout  = wdata_i[CNT_W-1:0];
				IACQ_OFS_PACE:   d.pace     = wdata_i;
				IACQ_OFS_LINES:  d.line_sel = wdata_i[7:0];
				IACQ_OFS_IRQ_MK: d.irq_mask = wdata_i[IACQ_IRQ_W-1:0];
				default: ;
			endcase
		end

		// Register reads, answered in the next cycle
		d.rdata = '0;
		if (rd_i) begin
			case (addr_i)
				IACQ_OFS_CTRL: begin
					d.rdata[IACQ_CTRL_SEL]   = q.trig_sel;
					d.rdata[IACQ_CTRL_MODE]  = (q.trig_sel == IACQ_TSEL_ACQ) ?
						q.acq_trig_on : q.frm_trig_on;
					d.rdata[IACQ_CTRL_CONT]  = q.cont;
					d.rdata[IACQ_CTRL_LIMIT] = q.limit_on;
				end
				IACQ_OFS_EXPOSE: d.rdata = 32'(q.exposure);
				IACQ_OFS_READ:   d.rdata = 32'(q.readout);
				IACQ_OFS_PACE:   d.rdata = q.pace;
				IACQ_OFS_EFF:    d.rdata = eff_per;
				IACQ_OFS_LINES:  d.rdata = 32'(q.line_sel);
				IACQ_OFS_STATUS: d.rdata = {24'h000000, line_o, arm_lvl, q.tx, exp_lvl,
					(q.state != IACQ_IDLE)};
				IACQ_OFS_IRQ_ST: begin
					d.rdata = 32'(q.irq_stat);
					ev_clr  = q.irq_stat;
				end
				IACQ_OFS_IRQ_MK: d.rdata = 32'(q.irq_mask);
				IACQ_OFS_FRAMES: d.rdata = q.frame_cnt;
				default: ;
			endcase
		end
		// New events win over the read that clears
		d.irq_stat = (q.irq_stat & ~ev_clr) | ev_set;
		d.irq      = |(d.irq_stat & d.irq_mask);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= RST_Q;
		end else begin
			q <= d;
		end
	end

	assign rdata_o    = q.rdata;
	assign irq_o      = q.irq;
	assign frame_tx_o = q.tx;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [31:0] exp_len;
	logic [31:0] exp_want;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			exp_len <= '0;
		end else if (tmr_load) begin
			exp_len <= '0;
		end else if (exp_lvl) begin
			exp_len <= exp_len + 32'h1;
		end
	end

	// Length that the running exposure must reach; a zero length lasts one cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			exp_want <= '0;
		end else if (tmr_load && (q.state != IACQ_EXPOSE)) begin
			exp_want <= (q.exposure == '0) ? 32'h1 : 32'(q.exposure);
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_line_one_exp: assert property ((q.line_sel[1:0] == IACQ_SRC_EXPOSE) |=>
		(line_o[0] == $past(exp_lvl)))
		else $error("line 1 does not follow exposure");

	a_line_two_arm: assert property ((q.line_sel[3:2] == IACQ_SRC_ARM) |=>
		(line_o[1] == $past(arm_lvl)))
		else $error("line 2 does not follow armable");

	a_line_off_low: assert property ((q.line_sel[5:4] == IACQ_SRC_OFF) ##1
		(q.line_sel[5:4] == IACQ_SRC_OFF) |-> !line_o[2])
		else $error("unused line 3 driven");

	a_single_stops: assert property ((q.state == IACQ_TRANSMIT) && tmr_done && !q.cont &&
		!stop_cmd |=> (q.state == IACQ_IDLE) ##1
		((q.state == IACQ_IDLE) || $past(start_cmd)))
		else $error("single frame did not stop");

	a_expose_len: assert property ($fell(exp_lvl) && tmr_done |->
		(exp_len == exp_want))
		else $error("exposure length wrong");

	a_cont_restart: assert property ((q.state == IACQ_PACE) && (q.period_cnt >= eff_per) &&
		!stop_cmd |=> (q.state == IACQ_EXPOSE) && exp_lvl)
		else $error("continuous mode did not restart");

	a_stop_halts: assert property (stop_cmd |=> (q.state == IACQ_IDLE) && !frame_tx_o &&
		!tmr_busy)
		else $error("stop did not halt acquisition");

	a_pace_exact: assert property ((q.state == IACQ_PACE) && tmr_load |->
		(q.period_cnt == eff_per))
		else $error("frame period not exact");

	a_eff_rate: assert property ((eff_per >= min_per) && (!q.limit_on -> (eff_per == min_per)))
		else $error("effective period wrong");

	a_trig_blocks: assert property ((q.state == IACQ_IDLE) && q.acq_trig_on |=>
		(q.state == IACQ_IDLE))
		else $error("started while trigger on");

	a_start_expose: assert property (start_cmd && !stop_cmd && (q.state == IACQ_IDLE) &&
		!q.acq_trig_on |=> exp_lvl)
		else $error("start did not begin exposure");

	a_tx_follows: assert property ((q.state == IACQ_EXPOSE) && tmr_done && !stop_cmd |=>
		frame_tx_o)
		else $error("transmission did not follow exposure");

	a_arm_apart: assert property (!(arm_lvl && exp_lvl))
		else $error("armable during exposure");

	a_irq_level: assert property (irq_o == |(q.irq_stat & q.irq_mask))
		else $error("interrupt level wrong");

	c_single_frame: cover property ((q.state == IACQ_TRANSMIT) && tmr_done && !q.cont);
	c_two_frames:   cover property ((q.state == IACQ_PACE) && tmr_load);
	c_stop_expose:  cover property (stop_cmd && (q.state == IACQ_EXPOSE));
	c_lines_moved:  cover property (q.line_sel != IACQ_LINES_RST);
	c_pace_limit:   cover property ((q.state == IACQ_PACE) && tmr_load && (eff_per > min_per));
endmodule

// ==== src/iacq_pkg.sv ====
// Constants, register map and types of the image acquisition sequencer
package iacq_pkg;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int unsigned IACQ_AW         = 8;
	localparam int unsigned IACQ_DW         = 32;

	localparam logic [7:0]  IACQ_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  IACQ_OFS_CMD    = 8'h04;
	localparam logic [7:0]  IACQ_OFS_EXPOSE = 8'h08;
	localparam logic [7:0]  IACQ_OFS_READ   = 8'h0C;
	localparam logic [7:0]  IACQ_OFS_PACE   = 8'h10;
	localparam logic [7:0]  IACQ_OFS_EFF    = 8'h14;
	localparam logic [7:0]  IACQ_OFS_LINES  = 8'h18;
	localparam logic [7:0]  IACQ_OFS_STATUS = 8'h1C;
	localparam logic [7:0]  IACQ_OFS_IRQ_ST = 8'h20;
	localparam logic [7:0]  IACQ_OFS_IRQ_MK = 8'h24;
	localparam logic [7:0]  IACQ_OFS_FRAMES = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned IACQ_CTRL_SEL   = 0;
	localparam int unsigned IACQ_CTRL_MODE  = 1;
	localparam int unsigned IACQ_CTRL_CONT  = 2;
	localparam int unsigned IACQ_CTRL_LIMIT = 3;
	localparam int unsigned IACQ_CMD_START  = 0;
	localparam int unsigned IACQ_CMD_STOP   = 1;
	localparam int unsigned IACQ_IRQ_DONE   = 0;
	localparam int unsigned IACQ_IRQ_STOP   = 1;
	localparam int unsigned IACQ_IRQ_IGN    = 2;
	localparam int unsigned IACQ_IRQ_W      = 3;
	localparam int unsigned IACQ_LINES      = 4;
	localparam int unsigned IACQ_SEL_W      = 2;

	// Trigger selector codes and line source codes
	localparam logic        IACQ_TSEL_ACQ   = 1'b0;
	localparam logic [1:0]  IACQ_SRC_EXPOSE = 2'h0;
	localparam logic [1:0]  IACQ_SRC_ARM    = 2'h1;
	localparam logic [1:0]  IACQ_SRC_TX     = 2'h2;
	localparam logic [1:0]  IACQ_SRC_OFF    = 2'h3;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] IACQ_EXPOSE_RST = 32'h000003E8;
	localparam logic [31:0] IACQ_READ_RST   = 32'h00001000;
	localparam logic [7:0]  IACQ_LINES_RST  = 8'hF4;
	// Cycles of sequencing overhead between two frame starts
	localparam logic [31:0] IACQ_OVERHEAD   = 32'h00000003;

	typedef enum logic [1:0] {
		IACQ_IDLE,
		IACQ_EXPOSE,
		IACQ_TRANSMIT,
		IACQ_PACE
	} iacq_state_t;

endpackage

// ==== src/iacq_stat_if.sv ====
// Status signals and line routing passed from the sequencer to the line driver
`timescale 1ns/10ps
interface iacq_stat_if;
	logic       exposing;
	logic       armable;
	logic       transmitting;
	logic [7:0] line_sel;

	modport src  (output exposing, output armable, output transmitting, output line_sel);
	modport sink (input exposing, input armable, input transmitting, input line_sel);
endinterface

// ==== src/iacq_phase_timer.sv ====
// Down-counter timing the exposure and transmission phases
`timescale 1ns/10ps
module iacq_phase_timer #(
	parameter int unsigned W = 24
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	// Control
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	input  wire logic         abort_i,
	// Status
	output logic              busy_o,
	output logic              done_o
);
	typedef struct packed {
		logic [W-1:0] left;
		logic         busy;
		logic         done;
	} iacq_tmr_t;

	iacq_tmr_t q;
	iacq_tmr_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (abort_i) begin
			d.busy = 1'b0;
		end else if (load_i) begin
			// A zero length still lasts one cycle
			d.left = (count_i == '0) ? W'(1) : count_i;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (q.left == W'(1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.left = q.left - W'(1);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy_o = q.busy;
	assign done_o = q.done;
endmodule

// ==== src/iacq_line_mux.sv ====
// Registered routing of internal status signals onto the four output lines
`timescale 1ns/10ps
module iacq_line_mux
	import iacq_pkg::*;
(
	// Clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   rst_n_i,
	// Status from the sequencer
	iacq_stat_if.sink                   stat,
	// Lines, high while the output transistor conducts
	output logic [IACQ_LINES-1:0]       line_o
);
	typedef struct packed {
		logic [IACQ_LINES-1:0] line;
	} iacq_mux_t;

	iacq_mux_t q;
	iacq_mux_t d;

	function automatic logic pick(input logic [1:0] src, input logic e, input logic a,
		input logic t);
		case (src)
			IACQ_SRC_EXPOSE: pick = e;
			IACQ_SRC_ARM:    pick = a;
			IACQ_SRC_TX:     pick = t;
			default:         pick = 1'b0;
		endcase
	endfunction

	always_comb begin
		d = q;
		for (int i = 0; i < IACQ_LINES; i++) begin
			d.line[i] = pick(stat.line_sel[i*IACQ_SEL_W +: IACQ_SEL_W], stat.exposing,
				stat.armable, stat.transmitting);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign line_o = q.line;
endmodule

// ==== testbench/iacq_watch.sv ====
// Model of the external equipment that watches the output lines and the frame output
`timescale 1ns/10ps
module iacq_watch
	import iacq_pkg::*;
(
	// Clock and clear
	input  wire logic                        mclk_i,
	input  wire logic                        clr_i,
	// Observed lines
	input  wire logic [IACQ_LINES-1:0]       line_i,
	input  wire logic                        tx_i,
	// Measurements
	output logic      [IACQ_LINES-1:0][15:0] hi_cnt_o,
	output logic      [15:0]                 tx_cnt_o,
	output logic      [15:0]                 rise_cnt_o,
	output logic      [15:0]                 period_o
);
	logic [IACQ_LINES-1:0] prev;
	logic [15:0]           gap;

	// ----------------------------------------------------------------
	// Counting of conducting cycles and exposure starts
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		prev <= line_i;
		if (clr_i) begin
			hi_cnt_o   <= '0;
			tx_cnt_o   <= '0;
			rise_cnt_o <= '0;
			period_o   <= '0;
			gap        <= '0;
		end else begin
			for (int i = 0; i < IACQ_LINES; i++) begin
				if (line_i[i] === 1'b1) begin
					hi_cnt_o[i] <= hi_cnt_o[i] + 16'h0001;
				end
			end
			if (tx_i === 1'b1) begin
				tx_cnt_o <= tx_cnt_o + 16'h0001;
			end
			gap <= gap + 16'h0001;
			// Spacing between two exposure starts on the first line
			if (line_i[0] === 1'b1 && prev[0] !== 1'b1) begin
				rise_cnt_o <= rise_cnt_o + 16'h0001;
				period_o   <= gap + 16'h0001;
				gap        <= '0;
			end
		end
	end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the image acquisition sequencer
`timescale 1ns/10ps
module tb
	import iacq_pkg::*;
;
	localparam logic [31:0] EXP_T = 32'h00000005;
	localparam logic [31:0] RD_T  = 32'h00000004;

	logic                        mclk_i  = 1'b0;
	logic                        rst_n_i = 1'b0;
	logic [IACQ_AW-1:0]          addr_i  = '0;
	logic [IACQ_DW-1:0]          wdata_i = '0;
	logic                        wr_i    = 1'b0;
	logic                        rd_i    = 1'b0;
	logic [IACQ_DW-1:0]          rdata_o;
	logic                        irq_o;
	logic                        frame_tx_o;
	logic [IACQ_LINES-1:0]       line_o;
	logic                        clr     = 1'b1;
	logic [IACQ_LINES-1:0][15:0] hi_cnt;
	logic [15:0]                 tx_cnt;
	logic [15:0]                 rise_cnt;
	logic [15:0]                 period;
	logic [31:0]                 rd_val;
	int                          err_total = 0;
	int                          cmp_count = 0;

	always #2 mclk_i = ~mclk_i;

	iacq_top #(.CNT_W(24)) u_dut (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.addr_i     (addr_i),
		.wdata_i    (wdata_i),
		.wr_i       (wr_i),
		.rd_i       (rd_i),
		.rdata_o    (rdata_o),
		.irq_o      (irq_o),
		.frame_tx_o (frame_tx_o),
		.line_o     (line_o)
	);

	iacq_watch u_watch (
		.mclk_i     (mclk_i),
		.clr_i      (clr),
		.line_i     (line_o),
		.tx_i       (frame_tx_o),
		.hi_cnt_o   (hi_cnt),
		.tx_cnt_o   (tx_cnt),
		.rise_cnt_o (rise_cnt),
		.period_o   (period)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i   <= 1'b0;
		#1;
		rd_val = rdata_o;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(what, exp, rd_val);
	endtask

	task automatic clear_watch();
		@(posedge mclk_i);
		clr <= 1'b1;
		@(posedge mclk_i);
		clr <= 1'b0;
	endtask

	// Waits for the end of one transmitted frame, bounded
	task automatic wait_done();
		int n;
		n = 0;
		while (frame_tx_o !== 1'b1 && n < 500) begin
			cyc(1);
			n++;
		end
		while (frame_tx_o !== 1'b0 && n < 500) begin
			cyc(1);
			n++;
		end
		chk("frame end wait", 32'h0, {31'h0, n >= 500});
		cyc(2);
	endtask

	// Free run, then stop; checks spacing of frame starts and the stop
	task automatic run_cont(input logic [31:0] p);
		logic [15:0] seen;
		clear_watch();
		wr_reg(IACQ_OFS_CMD, 32'h1);
		cyc(int'(4 * p + 8));
		chk("frame period", p, {16'h0, period});
		chk("repeated frames", 32'h1, {31'h0, rise_cnt >= 16'h0004});
		wr_reg(IACQ_OFS_CMD, 32'h2);
		cyc(2);
		chk("tx after stop", 32'h0, {31'h0, frame_tx_o});
		chk("exposure after stop", 32'h0, {31'h0, line_o[0]});
		seen = rise_cnt;
		cyc(int'(2 * p));
		chk("no frame after stop", {16'h0, seen}, {16'h0, rise_cnt});
		rd_reg(IACQ_OFS_IRQ_ST);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("idle lines", 32'h2, {28'h0, line_o});
		chk("idle irq", 32'h0, {31'h0, irq_o});
		rd_chk("ctrl", IACQ_OFS_CTRL, 32'h0);
		rd_chk("expose", IACQ_OFS_EXPOSE, IACQ_EXPOSE_RST);
		rd_chk("read", IACQ_OFS_READ, IACQ_READ_RST);
		rd_chk("lines", IACQ_OFS_LINES, {24'h0, IACQ_LINES_RST});
		// Idle: armable set, line 2 conducting
		rd_chk("status", IACQ_OFS_STATUS, 32'h28);
		wr_reg(IACQ_OFS_EFF, 32'h0);
		rd_chk("eff", IACQ_OFS_EFF, IACQ_EXPOSE_RST + IACQ_READ_RST + IACQ_OVERHEAD);
		rd_chk("unmapped", 8'h3C, 32'h0);
		wr_reg(IACQ_OFS_EXPOSE, EXP_T);
		wr_reg(IACQ_OFS_READ, RD_T);
		wr_reg(IACQ_OFS_IRQ_MK, 32'h7);
		rd_chk("irq mask", IACQ_OFS_IRQ_MK, 32'h7);
	endtask

	// Transmission spans its programmed count plus the hand-over cycle
	task automatic t_single();
		clear_watch();
		wr_reg(IACQ_OFS_CMD, 32'h1);
		wr_reg(IACQ_OFS_CMD, 32'h1);
		wait_done();
		chk("exposure cycles", EXP_T, {16'h0, hi_cnt[0]});
		chk("tx cycles", RD_T + 32'h1, {16'h0, tx_cnt});
		chk("armable after frame", 32'h1, {31'h0, line_o[1]});
		chk("irq raised", 32'h1, {31'h0, irq_o});
		rd_chk("irq status", IACQ_OFS_IRQ_ST, 32'h5);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		rd_chk("frames", IACQ_OFS_FRAMES, 32'h1);
		cyc(30);
		chk("one frame only", 32'h1, {16'h0, rise_cnt});
	endtask

	task automatic t_lines();
		wr_reg(IACQ_OFS_LINES, 32'hD2);
		clear_watch();
		wr_reg(IACQ_OFS_CMD, 32'h1);
		wait_done();
		chk("line 1 shows tx", RD_T + 32'h1, {16'h0, hi_cnt[0]});
		chk("line 2 shows exposure", EXP_T, {16'h0, hi_cnt[1]});
		chk("line 3 shows armable", 32'h1, {31'h0, line_o[2]});
		chk("line 4 off", 32'h0, {16'h0, hi_cnt[3]});
		wr_reg(IACQ_OFS_LINES, {24'h0, IACQ_LINES_RST});
		rd_reg(IACQ_OFS_IRQ_ST);
	endtask

	task automatic t_rate();
		wr_reg(IACQ_OFS_CTRL, 32'h4);
		run_cont(EXP_T + RD_T + IACQ_OVERHEAD);
		wr_reg(IACQ_OFS_PACE, 32'h1E);
		wr_reg(IACQ_OFS_CTRL, 32'hC);
		rd_chk("pace", IACQ_OFS_PACE, 32'h1E);
		rd_chk("eff limited", IACQ_OFS_EFF, 32'h1E);
		run_cont(32'h1E);
		wr_reg(IACQ_OFS_PACE, 32'h5);
		rd_chk("eff capped", IACQ_OFS_EFF, EXP_T + RD_T + IACQ_OVERHEAD);
		run_cont(EXP_T + RD_T + IACQ_OVERHEAD);
		wr_reg(IACQ_OFS_CTRL, 32'h0);
	endtask

	task automatic t_trig();
		wr_reg(IACQ_OFS_CTRL, 32'h2);
		rd_chk("trigger on", IACQ_OFS_CTRL, 32'h2);
		clear_watch();
		wr_reg(IACQ_OFS_CMD, 32'h1);
		cyc(20);
		chk("start blocked", 32'h0, {16'h0, rise_cnt});
		rd_chk("start ignored", IACQ_OFS_IRQ_ST, 32'h4);
		// Frame start trigger on must not hold back an untriggered start
		wr_reg(IACQ_OFS_CTRL, 32'h3);
		rd_chk("frame trigger", IACQ_OFS_CTRL, 32'h3);
		// Select the acquisition trigger, then switch its mode off
		wr_reg(IACQ_OFS_CTRL, 32'h2);
		rd_chk("acq trigger still on", IACQ_OFS_CTRL, 32'h2);
		wr_reg(IACQ_OFS_CTRL, 32'h0);
		rd_chk("acq trigger off", IACQ_OFS_CTRL, 32'h0);
		wr_reg(IACQ_OFS_CMD, 32'h1);
		wait_done();
		chk("untriggered frame", 32'h1, {16'h0, rise_cnt});
		rd_reg(IACQ_OFS_IRQ_ST);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		cyc(3);
		t_reset();
		t_single();
		t_lines();
		t_rate();
		t_trig();
		stop_test();
	end

	initial begin
		#40000;
		err_total++;
		stop_test();
	end
endmodule
